// ---- bfp_pkg.sv ----
// constants and types shared by the branch fold and predict unit
package bfp_pkg;
	localparam int ADDR_W = 32;
	localparam int INSTR_W = 32;
	localparam int HIST_N = 16;
	localparam int HIST_IDX_W = 4;
	localparam int HIST_IDX_LSB = 2;
	localparam int TC_N = 4;
	localparam int TC_IDX_W = 2;
	localparam logic [1:0] HIST_RESET = 2'h1;
	localparam logic [1:0] HIST_MAX = 2'h3;
	localparam logic [1:0] HIST_MIN = 2'h0;
	localparam logic [31:0] INSTR_STEP = 32'h4;
	localparam logic [31:0] TC_STEP = 32'h8;
	typedef enum logic [2:0] {
		F_IDLE = 3'h0,
		F_TC_HIT = 3'h1,
		F_MISS_IDLE = 3'h2,
		F_L1_FETCH = 3'h3,
		F_L2_WAIT = 3'h4
	} bfp_fetch_t;
endpackage

// ---- bfp_branch_unit.sv ----
// branch fold, predict, target cache and fetch redirect logic of the front end
// Function
// - branches not writing link or count are removed from the stream, taken ones folded, not-taken ones discarded at dispatch
// - link or count writing branches stay queued and take a completion slot
// - link and count updates commit at completion in program order
// - unresolved branches are predicted and later fetched instructions marked conditional
// - a correct prediction validates its conditional instructions for normal retirement
// - misprediction purges queue, flushes younger work, restarts fetch on correct path
// - instructions after an unresolved prediction may execute but never retire
// - beyond a second-level prediction instructions are fetched but not executed
// - a third condition branch with two unresolved stalls fetch until one resolves
// - when the count condition alone resolves, condition dependency is ignored
// - finished speculative work waits; dispatch stops while completion queue is full
// - target cache hit delivers two target instructions on the next cycle
// - after a target cache hit the next four are fetched next clock
// - target cache miss inserts one idle cycle then fetches four targets
// - on a level-one miss the target is requested further out, any latency
// - target cache fully resets on flash invalidate, block invalidate, return, exception
// - move to link or count stalls fetch of a dependent branch until executed
// - with the history enable clear, prediction follows the branch options hint
// - with history enabled, recorded behaviour predicts later occurrences
// - taken branches found early are folded with wrong-path instructions, zero latency
// - not-taken branches are discarded at dispatch, costing that entry one cycle
`timescale 1ns/1ps
module bfp_branch_unit
	import bfp_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_enable,
	input wire logic i_hist_enable,
	input wire logic i_br_valid,
	input wire logic i_br_cond,
	input wire logic i_br_cond_pending,
	input wire logic i_br_cond_taken,
	input wire logic i_br_count_resolves,
	input wire logic i_br_count_taken,
	input wire logic i_br_writes_link_count,
	input wire logic i_br_needs_link,
	input wire logic i_br_needs_count,
	input wire logic i_br_hint_taken,
	input wire logic [ADDR_W-1:0] i_br_pc,
	input wire logic [ADDR_W-1:0] i_br_target,
	input wire logic i_mov_link_pending,
	input wire logic i_mov_count_pending,
	input wire logic i_res_valid,
	input wire logic i_res_slot,
	input wire logic i_res_taken,
	input wire logic i_disp_keep_valid,
	input wire logic i_cq_full,
	input wire logic i_cq_head_valid,
	input wire logic i_cq_head_done,
	input wire logic [1:0] i_cq_head_mask,
	input wire logic i_cq_head_link_count,
	input wire logic i_tc_inval_flash,
	input wire logic i_icbi_exec,
	input wire logic i_rfi_exec,
	input wire logic i_exception,
	input wire logic i_l1_ack,
	input wire logic i_l1_miss,
	input wire logic [INSTR_W-1:0] i_l1_instr0,
	input wire logic [INSTR_W-1:0] i_l1_instr1,
	input wire logic i_l2_done,
	output logic o_br_accept,
	output logic o_fetch_stall,
	output logic o_fold,
	output logic o_discard_at_dispatch,
	output logic o_keep_in_queue,
	output logic o_queue_purge,
	output logic [1:0] o_cond_mask,
	output logic [1:0] o_exec_block_mask,
	output logic o_retire_ok,
	output logic o_link_count_commit,
	output logic o_cq_alloc,
	output logic o_dispatch_stall,
	output logic o_validate,
	output logic [1:0] o_validate_mask,
	output logic o_flush,
	output logic [1:0] o_flush_mask,
	output logic o_tc_deliver,
	output logic [INSTR_W-1:0] o_tc_instr0,
	output logic [INSTR_W-1:0] o_tc_instr1,
	output logic o_fetch_req,
	output logic [ADDR_W-1:0] o_fetch_addr,
	output logic o_l2_req
);

	function automatic logic [1:0] sat_step(input logic [1:0] c, input logic t);
		if (t) begin
			sat_step = (c == HIST_MAX) ? c : c + 2'h1;
		end else begin
			sat_step = (c == HIST_MIN) ? c : c - 2'h1;
		end
	endfunction

	function automatic logic [TC_IDX_W-1:0] onehot_idx(input logic [TC_N-1:0] v);
		onehot_idx = '0;
		for (int k = 0; k < TC_N; k++) begin
			if (v[k]) begin
				onehot_idx = TC_IDX_W'(k);
			end
		end
	endfunction

	logic rst_meta_reg;
	logic rstn_reg;

	// internal reset is asserted at once but released only after two clean edges
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_reg <= 1'b0;
			rstn_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rstn_reg <= rst_meta_reg;
		end
	end

	logic [1:0] slot_valid_reg, slot_valid_next;
	logic [1:0] slot_pred_reg, slot_pred_next;
	logic slot_old_reg, slot_old_next;
	logic [ADDR_W-1:0] slot_alt_reg [2];
	logic [ADDR_W-1:0] slot_alt_next [2];
	logic [HIST_IDX_W-1:0] slot_hidx_reg [2];
	logic [HIST_IDX_W-1:0] slot_hidx_next [2];
	logic [1:0] hist_reg [HIST_N];
	logic [1:0] hist_next [HIST_N];
	logic [TC_N-1:0] tc_valid_reg, tc_valid_next;
	logic [ADDR_W-1:0] tc_tag_reg [TC_N];
	logic [ADDR_W-1:0] tc_tag_next [TC_N];
	logic [INSTR_W-1:0] tc_i0_reg [TC_N];
	logic [INSTR_W-1:0] tc_i0_next [TC_N];
	logic [INSTR_W-1:0] tc_i1_reg [TC_N];
	logic [INSTR_W-1:0] tc_i1_next [TC_N];
	logic [TC_IDX_W-1:0] tc_ptr_reg, tc_ptr_next;
	bfp_fetch_t fstate_reg, fstate_next;
	logic [ADDR_W-1:0] fetch_addr_reg, fetch_addr_next;
	logic miss_reg, miss_next;
	logic [INSTR_W-1:0] out_i0_reg, out_i0_next;
	logic [INSTR_W-1:0] out_i1_reg, out_i1_next;

	logic [HIST_IDX_W-1:0] br_hidx;
	logic need_pred, dep_stall, depth_stall, busy;
	logic mispredict, correct, accept, pred_taken, taken, redirect;
	logic free_slot, tc_hit, tc_inval, fill_en;
	logic [ADDR_W-1:0] redirect_addr;
	logic [1:0] flush_mask;
	logic [TC_N-1:0] tc_hit_vec;
	logic [TC_IDX_W-1:0] tc_hit_idx;

	assign br_hidx = i_br_pc[HIST_IDX_LSB +: HIST_IDX_W];
	assign need_pred = i_br_cond & i_br_cond_pending & ~i_br_count_resolves;
	assign dep_stall = (i_br_needs_link & i_mov_link_pending)
		| (i_br_needs_count & i_mov_count_pending);
	assign depth_stall = need_pred & (&slot_valid_reg);
	assign busy = (fstate_reg != F_IDLE);
	assign mispredict = i_enable & i_res_valid & slot_valid_reg[i_res_slot]
		& (slot_pred_reg[i_res_slot] != i_res_taken);
	assign correct = i_enable & i_res_valid & slot_valid_reg[i_res_slot]
		& (slot_pred_reg[i_res_slot] == i_res_taken);
	// a branch is not taken while the fetcher is still being steered elsewhere
	assign accept = i_enable & i_br_valid & ~dep_stall & ~depth_stall & ~busy & ~mispredict;
	assign pred_taken = i_hist_enable ? hist_reg[br_hidx][1] : i_br_hint_taken;
	assign taken = need_pred ? pred_taken
		: (~i_br_cond | (i_br_count_resolves ? i_br_count_taken : i_br_cond_taken));
	assign redirect = mispredict | (accept & taken);
	assign redirect_addr = mispredict ? slot_alt_reg[i_res_slot] : i_br_target;
	assign free_slot = slot_valid_reg[0];

	always_comb begin
		slot_valid_next = slot_valid_reg;
		slot_pred_next = slot_pred_reg;
		slot_old_next = slot_old_reg;
		slot_alt_next = slot_alt_reg;
		slot_hidx_next = slot_hidx_reg;
		flush_mask = 2'h0;
		if (mispredict) begin
			flush_mask[i_res_slot] = 1'b1;
			if (slot_valid_reg[~i_res_slot] && (slot_old_reg == i_res_slot)) begin
				flush_mask[~i_res_slot] = 1'b1;
			end
			slot_valid_next = slot_valid_reg & ~flush_mask;
		end else begin
			if (correct) begin
				slot_valid_next[i_res_slot] = 1'b0;
			end
			if (accept && need_pred) begin
				slot_valid_next[free_slot] = 1'b1;
				slot_pred_next[free_slot] = taken;
				slot_alt_next[free_slot] = taken ? i_br_pc + INSTR_STEP : i_br_target;
				slot_hidx_next[free_slot] = br_hidx;
				slot_old_next = slot_valid_next[~free_slot] ? ~free_slot : free_slot;
			end
		end
		if (!slot_valid_next[slot_old_next]) begin
			slot_old_next = ~slot_old_next;
		end
	end

	always_ff @(posedge i_clock or negedge rstn_reg) begin
		if (!rstn_reg) begin
			slot_valid_reg <= 2'h0;
			slot_pred_reg <= 2'h0;
			slot_old_reg <= 1'b0;
			for (int k = 0; k < 2; k++) begin
				slot_alt_reg[k] <= '0;
				slot_hidx_reg[k] <= '0;
			end
		end else if (i_enable) begin
			slot_valid_reg <= slot_valid_next;
			slot_pred_reg <= slot_pred_next;
			slot_old_reg <= slot_old_next;
			slot_alt_reg <= slot_alt_next;
			slot_hidx_reg <= slot_hidx_next;
		end
	end

	// counters learn from every resolved prediction while history is enabled
	always_comb begin
		hist_next = hist_reg;
		if ((correct || mispredict) && i_hist_enable) begin
			hist_next[slot_hidx_reg[i_res_slot]] =
				sat_step(hist_reg[slot_hidx_reg[i_res_slot]], i_res_taken);
		end
	end

	always_ff @(posedge i_clock or negedge rstn_reg) begin
		if (!rstn_reg) begin
			for (int k = 0; k < HIST_N; k++) begin
				hist_reg[k] <= HIST_RESET;
			end
		end else if (i_enable) begin
			hist_reg <= hist_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < TC_N; g++) begin : g_tc_match
			assign tc_hit_vec[g] = tc_valid_reg[g] && (tc_tag_reg[g] == redirect_addr);
		end
	endgenerate
	assign tc_hit = |tc_hit_vec;
	assign tc_hit_idx = onehot_idx(tc_hit_vec);
	assign tc_inval = i_tc_inval_flash | i_icbi_exec | i_rfi_exec | i_exception;
	assign fill_en = (fstate_reg == F_L1_FETCH) & miss_reg & i_l1_ack & ~i_l1_miss;

	// invalidation beats a fill in the same cycle so no stale pair survives
	always_comb begin
		tc_valid_next = tc_valid_reg;
		tc_tag_next = tc_tag_reg;
		tc_i0_next = tc_i0_reg;
		tc_i1_next = tc_i1_reg;
		tc_ptr_next = tc_ptr_reg;
		if (tc_inval) begin
			tc_valid_next = '0;
		end else if (fill_en) begin
			tc_valid_next[tc_ptr_reg] = 1'b1;
			tc_tag_next[tc_ptr_reg] = fetch_addr_reg;
			tc_i0_next[tc_ptr_reg] = i_l1_instr0;
			tc_i1_next[tc_ptr_reg] = i_l1_instr1;
			tc_ptr_next = tc_ptr_reg + TC_IDX_W'(1);
		end
	end

	always_ff @(posedge i_clock or negedge rstn_reg) begin
		if (!rstn_reg) begin
			tc_valid_reg <= '0;
			tc_ptr_reg <= '0;
			for (int k = 0; k < TC_N; k++) begin
				tc_tag_reg[k] <= '0;
				tc_i0_reg[k] <= '0;
				tc_i1_reg[k] <= '0;
			end
		end else if (i_enable) begin
			tc_valid_reg <= tc_valid_next;
			tc_ptr_reg <= tc_ptr_next;
			tc_tag_reg <= tc_tag_next;
			tc_i0_reg <= tc_i0_next;
			tc_i1_reg <= tc_i1_next;
		end
	end

	always_comb begin
		fstate_next = fstate_reg;
		fetch_addr_next = fetch_addr_reg;
		miss_next = miss_reg;
		out_i0_next = out_i0_reg;
		out_i1_next = out_i1_reg;
		if (redirect) begin
			fetch_addr_next = redirect_addr;
			if (tc_hit) begin
				fstate_next = F_TC_HIT;
				miss_next = 1'b0;
				out_i0_next = tc_i0_reg[tc_hit_idx];
				out_i1_next = tc_i1_reg[tc_hit_idx];
			end else begin
				fstate_next = F_MISS_IDLE;
				miss_next = 1'b1;
			end
		end else begin
			case (fstate_reg)
				F_IDLE: begin
					fstate_next = F_IDLE;
				end
				F_TC_HIT: begin
					fstate_next = F_L1_FETCH;
					fetch_addr_next = fetch_addr_reg + TC_STEP;
				end
				F_MISS_IDLE: begin
					fstate_next = F_L1_FETCH;
				end
				F_L1_FETCH: begin
					if (i_l1_miss) begin
						fstate_next = F_L2_WAIT;
					end else if (i_l1_ack) begin
						fstate_next = F_IDLE;
					end
				end
				F_L2_WAIT: begin
					if (i_l2_done) begin
						fstate_next = F_IDLE;
					end
				end
				default: begin
					fstate_next = F_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge rstn_reg) begin
		if (!rstn_reg) begin
			fstate_reg <= F_IDLE;
			fetch_addr_reg <= '0;
			miss_reg <= 1'b0;
			out_i0_reg <= '0;
			out_i1_reg <= '0;
		end else if (i_enable) begin
			fstate_reg <= fstate_next;
			fetch_addr_reg <= fetch_addr_next;
			miss_reg <= miss_next;
			out_i0_reg <= out_i0_next;
			out_i1_reg <= out_i1_next;
		end
	end

	assign o_br_accept = accept;
	assign o_fetch_stall = i_br_valid & (dep_stall | depth_stall);
	assign o_fold = accept & ~i_br_writes_link_count & taken;
	assign o_discard_at_dispatch = accept & ~i_br_writes_link_count & ~taken;
	assign o_keep_in_queue = accept & i_br_writes_link_count;
	assign o_queue_purge = (accept & taken) | mispredict;
	assign o_cond_mask = slot_valid_reg;
	// only the younger of two live predictions holds back execution
	assign o_exec_block_mask = {2{&slot_valid_reg}} & {~slot_old_reg, slot_old_reg};
	assign o_retire_ok = i_enable & i_cq_head_valid & i_cq_head_done
		& ~|(i_cq_head_mask & slot_valid_reg);
	assign o_link_count_commit = o_retire_ok & i_cq_head_link_count;
	assign o_cq_alloc = i_enable & i_disp_keep_valid & ~i_cq_full;
	assign o_dispatch_stall = i_cq_full;
	assign o_validate = correct;
	assign o_validate_mask = {2{correct}} & {i_res_slot, ~i_res_slot};
	assign o_flush = mispredict;
	assign o_flush_mask = flush_mask;
	assign o_tc_deliver = (fstate_reg == F_TC_HIT);
	assign o_tc_instr0 = out_i0_reg;
	assign o_tc_instr1 = out_i1_reg;
	assign o_fetch_req = (fstate_reg == F_L1_FETCH);
	assign o_fetch_addr = fetch_addr_reg;
	assign o_l2_req = (fstate_reg == F_L2_WAIT);

	AST_FOLD_CLEAN: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		o_fold |-> !i_br_writes_link_count && !o_keep_in_queue)
		else $error("folded branch writes link or count");
	AST_KEEP_ALLOC: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		i_enable && i_disp_keep_valid && !i_cq_full |-> o_cq_alloc)
		else $error("kept branch got no completion slot");
	AST_COMMIT_ORDER: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		o_link_count_commit |-> i_cq_head_valid && i_cq_head_done)
		else $error("link or count commit out of completion");
	AST_MARK: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		accept && need_pred && !correct |=> o_cond_mask != 2'h0)
		else $error("prediction not marked conditional");
	AST_VALIDATE: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		o_validate && !(accept && need_pred) |=> !slot_valid_reg[$past(i_res_slot)])
		else $error("validated prediction still live");
	AST_FLUSH_RESTART: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		o_flush |=> (o_tc_deliver || !o_fetch_req) ##1
			(o_fetch_req || !$past(i_enable) || $past(o_flush)))
		else $error("misprediction did not restart fetch");
	AST_NO_SPEC_RETIRE: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		o_retire_ok |-> (i_cq_head_mask & slot_valid_reg) == 2'h0)
		else $error("speculative instruction retired");
	AST_SECOND_LEVEL: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		slot_valid_reg == 2'h3 |-> $onehot(o_exec_block_mask))
		else $error("second level work not held");
	AST_DEPTH_STALL: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		i_br_valid && need_pred && slot_valid_reg == 2'h3 |-> o_fetch_stall && !o_br_accept)
		else $error("third prediction accepted");
	AST_TC_HIT: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		redirect && tc_hit |=> o_tc_deliver ##1
			(o_fetch_req || !$past(i_enable) || $past(o_flush)))
		else $error("target cache hit sequence broken");
	AST_TC_MISS: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		redirect && !tc_hit |=> !o_fetch_req && !o_tc_deliver)
		else $error("no idle cycle after target cache miss");
	AST_INVAL: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		i_enable && tc_inval |=> tc_valid_reg == '0)
		else $error("target cache survived invalidation");
	AST_MOVE_STALL: assert property (@(posedge i_clock) disable iff (!rstn_reg)
		i_br_valid && dep_stall |-> o_fetch_stall && !o_br_accept)
		else $error("branch passed a pending move");
endmodule

// ---- bfp_fetch_partner.sv ----
// fetch-side memory model answering level-one and level-two requests of the unit
`timescale 1ns/1ps
module bfp_fetch_partner
	import bfp_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_fetch_req,
	input wire logic [ADDR_W-1:0] i_fetch_addr,
	input wire logic i_l2_req,
	input wire logic i_miss,
	input wire logic [3:0] i_delay,
	output logic o_l1_ack,
	output logic o_l1_miss,
	output logic [INSTR_W-1:0] o_l1_instr0,
	output logic [INSTR_W-1:0] o_l1_instr1,
	output logic o_l2_done
);
	logic [3:0] wait_reg;
	// answers move on the falling edge so the unit samples them settled
	always @(negedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			{o_l1_ack, o_l1_miss, o_l2_done} <= 3'h0;
			wait_reg <= 4'h0;
			o_l1_instr0 <= 32'h0;
			o_l1_instr1 <= 32'h0;
		end else begin
			{o_l1_ack, o_l1_miss, o_l2_done} <= 3'h0;
			wait_reg <= 4'h0;
			// data is not held between answers, so stale values never look valid
			o_l1_instr0 <= ~o_l1_instr0;
			o_l1_instr1 <= ~o_l1_instr1;
			if ((i_fetch_req || i_l2_req) && !(o_l1_ack || o_l1_miss || o_l2_done)) begin
				if (wait_reg < i_delay) begin
					wait_reg <= wait_reg + 4'h1;
				end else if (i_l2_req) begin
					o_l2_done <= 1'b1;
				end else if (i_miss) begin
					o_l1_miss <= 1'b1;
				end else begin
					o_l1_ack <= 1'b1;
					o_l1_instr0 <= ~i_fetch_addr;
					o_l1_instr1 <= ~(i_fetch_addr + INSTR_STEP);
				end
			end
		end
	end
endmodule

// ---- bfp_branch_unit_tb.sv ----
// self-checking bench for the branch fold and predict unit
`timescale 1ns/1ps
module bfp_branch_unit_tb
	import bfp_pkg::*;
;
	logic i_clock, i_rstn, i_enable, i_hist_enable, i_br_valid, i_br_cond, i_br_cond_pending;
	logic i_br_cond_taken, i_br_count_resolves, i_br_count_taken, i_br_writes_link_count;
	logic i_br_needs_link, i_br_needs_count, i_br_hint_taken, i_mov_link_pending;
	logic i_mov_count_pending, i_res_valid, i_res_slot, i_res_taken, i_disp_keep_valid;
	logic i_cq_full, i_cq_head_valid, i_cq_head_done, i_cq_head_link_count, i_tc_inval_flash;
	logic i_icbi_exec, i_rfi_exec, i_exception, i_l1_ack, i_l1_miss, i_l2_done, p_miss;
	logic [1:0] i_cq_head_mask, o_cond_mask, o_exec_block_mask, o_validate_mask, o_flush_mask;
	logic [ADDR_W-1:0] i_br_pc, i_br_target, o_fetch_addr;
	logic [INSTR_W-1:0] i_l1_instr0, i_l1_instr1, o_tc_instr0, o_tc_instr1;
	logic o_br_accept, o_fetch_stall, o_fold, o_discard_at_dispatch, o_keep_in_queue;
	logic o_queue_purge, o_retire_ok, o_link_count_commit, o_cq_alloc, o_dispatch_stall;
	logic o_validate, o_flush, o_tc_deliver, o_fetch_req, o_l2_req;
	logic [3:0] p_delay;
	logic [2:0] r;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	time rel_t = 0;
	// rows: cond, pending, cond_taken, count_resolves, count_taken, writes, hint | fold, discard, keep
	logic [9:0] rows [6] = '{10'b0000000100, 10'b1010000100, 10'b1000000010,
		10'b1101100100, 10'b1111001010, 10'b1000010001};

	bfp_branch_unit u_dut (.i_clock, .i_rstn, .i_enable, .i_hist_enable, .i_br_valid, .i_br_cond,
		.i_br_cond_pending, .i_br_cond_taken, .i_br_count_resolves, .i_br_count_taken,
		.i_br_writes_link_count, .i_br_needs_link, .i_br_needs_count, .i_br_hint_taken,
		.i_br_pc, .i_br_target, .i_mov_link_pending, .i_mov_count_pending, .i_res_valid,
		.i_res_slot, .i_res_taken, .i_disp_keep_valid, .i_cq_full, .i_cq_head_valid,
		.i_cq_head_done, .i_cq_head_mask, .i_cq_head_link_count, .i_tc_inval_flash,
		.i_icbi_exec, .i_rfi_exec, .i_exception, .i_l1_ack, .i_l1_miss, .i_l1_instr0,
		.i_l1_instr1, .i_l2_done, .o_br_accept, .o_fetch_stall, .o_fold,
		.o_discard_at_dispatch, .o_keep_in_queue, .o_queue_purge, .o_cond_mask,
		.o_exec_block_mask, .o_retire_ok, .o_link_count_commit, .o_cq_alloc, .o_dispatch_stall,
		.o_validate, .o_validate_mask, .o_flush, .o_flush_mask, .o_tc_deliver, .o_tc_instr0,
		.o_tc_instr1, .o_fetch_req, .o_fetch_addr, .o_l2_req);

	bfp_fetch_partner u_mem (.i_clock, .i_rstn, .i_fetch_req(o_fetch_req),
		.i_fetch_addr(o_fetch_addr), .i_l2_req(o_l2_req), .i_miss(p_miss), .i_delay(p_delay),
		.o_l1_ack(i_l1_ack), .o_l1_miss(i_l1_miss), .o_l1_instr0(i_l1_instr0),
		.o_l1_instr1(i_l1_instr1), .o_l2_done(i_l2_done));

	task automatic finish_test();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// holds the branch until taken in, then releases it after that edge
	task automatic br(input logic [6:0] f, input logic [31:0] pc, tgt, output logic [2:0] q);
		// a new branch never rises in the step in which the last one was released
		if (rel_t == $time) begin
			@(negedge i_clock);
		end
		{i_br_cond, i_br_cond_pending, i_br_cond_taken, i_br_count_resolves, i_br_count_taken,
			i_br_writes_link_count, i_br_hint_taken} = f;
		i_br_pc = pc;
		i_br_target = tgt;
		i_br_valid = 1'b1;
		n = 0;
		#1;
		while (o_br_accept !== 1'b1 && n < 30) begin
			@(negedge i_clock);
			#1;
			n++;
		end
		q = {o_fold, o_discard_at_dispatch, o_keep_in_queue};
		chk(o_br_accept, 1'b1);
		@(negedge i_clock);
		i_br_valid = 1'b0;
		rel_t = $time;
	endtask

	task automatic redir(input logic hit, input logic [31:0] tgt);
		chk(o_tc_deliver, hit);
		chk(o_fetch_req, 1'b0);
		if (hit) begin
			chk(o_tc_instr0, ~tgt);
			chk(o_tc_instr1, ~(tgt + INSTR_STEP));
		end
		@(negedge i_clock);
		chk(o_fetch_req, 1'b1);
		chk(o_fetch_addr, hit ? tgt + TC_STEP : tgt);
	endtask

	task automatic res(input logic s, tk, v, input logic [1:0] m);
		i_res_valid = 1'b1;
		i_res_slot = s;
		i_res_taken = tk;
		#1;
		chk(o_validate, v);
		chk(o_flush, !v);
		chk(v ? o_validate_mask : o_flush_mask, m);
		chk(o_queue_purge, !v);
		@(negedge i_clock);
		i_res_valid = 1'b0;
	endtask

	always #5 i_clock = ~i_clock;

	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end

	initial begin
		{i_clock, i_rstn, i_hist_enable, i_br_valid, i_mov_link_pending} = 5'h0;
		{i_mov_count_pending, i_br_needs_link, i_br_needs_count, i_res_valid} = 4'h0;
		{i_res_slot, i_res_taken, i_disp_keep_valid, i_cq_full, i_cq_head_valid} = 5'h0;
		{i_cq_head_done, i_cq_head_link_count, i_tc_inval_flash, i_icbi_exec} = 4'h0;
		{i_rfi_exec, i_exception, p_miss, i_cq_head_mask} = 5'h0;
		i_enable = 1'b1;
		p_delay = 4'h0;
		{i_br_cond, i_br_cond_pending, i_br_cond_taken, i_br_count_resolves} = 4'h0;
		{i_br_count_taken, i_br_writes_link_count, i_br_hint_taken} = 3'h0;
		{i_br_pc, i_br_target} = 64'h0;
		#1;
		repeat (2) @(negedge i_clock);
		i_rstn = 1'b1;
		repeat (3) @(negedge i_clock);
		chk(o_cond_mask, 2'h0);
		chk(o_l2_req, 1'b0);
		for (int i = 0; i < 6; i++) begin
			br(rows[i][9:3], 32'h40 + 32'(i * 4), 32'h1000 + 32'(i * 64), r);
			chk(r, rows[i][2:0]);
			chk(o_cond_mask, 2'h0);
		end
		i_cq_full = 1'b1;
		i_disp_keep_valid = 1'b1;
		#1;
		chk(o_dispatch_stall, 1'b1);
		i_cq_full = 1'b0;
		#1;
		chk(o_dispatch_stall, 1'b0);
		chk(o_cq_alloc, 1'b1);
		i_disp_keep_valid = 1'b0;
		br(7'h00, 32'h200, 32'h2000, r);
		redir(1'b0, 32'h2000);
		for (int k = 0; k < 4; k++) begin
			br(7'h00, 32'h200, 32'h2000, r);
			redir(1'b1, 32'h2000);
			{i_tc_inval_flash, i_icbi_exec, i_rfi_exec, i_exception} = 4'h1 << k;
			@(negedge i_clock);
			{i_tc_inval_flash, i_icbi_exec, i_rfi_exec, i_exception} = 4'h0;
			br(7'h00, 32'h200, 32'h2000, r);
			redir(1'b0, 32'h2000);
		end
		br(7'b1100000, 32'h300, 32'h3000, r);
		chk(r, 3'b010);
		chk(o_cond_mask, 2'h1);
		br(7'b1100000, 32'h304, 32'h3100, r);
		chk(o_cond_mask, 2'h3);
		chk(o_exec_block_mask, 2'h2);
		@(negedge i_clock);
		i_br_valid = 1'b1;
		@(negedge i_clock);
		chk(o_br_accept, 1'b0);
		chk(o_fetch_stall, 1'b1);
		i_br_valid = 1'b0;
		{i_cq_head_valid, i_cq_head_done, i_cq_head_link_count, i_cq_head_mask} = 5'h1D;
		#1;
		chk(o_retire_ok, 1'b0);
		chk(o_link_count_commit, 1'b0);
		i_cq_head_mask = 2'h0;
		#1;
		chk(o_retire_ok, 1'b1);
		chk(o_link_count_commit, 1'b1);
		{i_cq_head_valid, i_cq_head_done, i_cq_head_link_count} = 3'h0;
		res(1'b0, 1'b0, 1'b1, 2'h1);
		chk(o_cond_mask, 2'h2);
		chk(o_exec_block_mask, 2'h0);
		br(7'b1100000, 32'h308, 32'h3200, r);
		chk(o_cond_mask, 2'h3);
		res(1'b1, 1'b1, 1'b0, 2'h3);
		chk(o_cond_mask, 2'h0);
		redir(1'b0, 32'h3100);
		i_hist_enable = 1'b1;
		br(7'b1100001, 32'h340, 32'h3400, r);
		chk(r, 3'b010);
		res(1'b0, 1'b1, 1'b0, 2'h1);
		br(7'b1100000, 32'h340, 32'h3400, r);
		chk(r, 3'b100);
		res(1'b0, 1'b1, 1'b1, 2'h1);
		i_hist_enable = 1'b0;
		br(7'b1100000, 32'h340, 32'h3400, r);
		chk(r, 3'b010);
		res(1'b0, 1'b0, 1'b1, 2'h1);
		for (int k = 0; k < 2; k++) begin
			@(negedge i_clock);
			{i_mov_link_pending, i_mov_count_pending} = k ? 2'b01 : 2'b10;
			{i_br_needs_link, i_br_needs_count} = k ? 2'b01 : 2'b10;
			{i_br_cond, i_br_cond_pending} = 2'b00;
			i_br_valid = 1'b1;
			@(negedge i_clock);
			chk(o_br_accept, 1'b0);
			chk(o_fetch_stall, 1'b1);
			{i_mov_link_pending, i_mov_count_pending} = 2'b00;
			br(7'h00, 32'h400, 32'h4000, r);
			chk(r, 3'b100);
		end
		{i_br_needs_link, i_br_needs_count} = 2'b00;
		p_miss = 1'b1;
		p_delay = 4'h2;
		br(7'h00, 32'h500, 32'h5000, r);
		while (o_l2_req !== 1'b1 && n < 40) begin
			@(negedge i_clock);
			n++;
		end
		chk(o_l2_req, 1'b1);
		p_miss = 1'b0;
		while (o_l2_req !== 1'b0 && n < 80) begin
			@(negedge i_clock);
			n++;
		end
		chk(o_l2_req, 1'b0);
		finish_test();
	end
endmodule
